//--- design/dcs_classifier.sv
`timescale 1ns/10ps
// Maps a master's bus priority or identifier onto a service class
module dcs_classifier
   import dcs_pkg::*;
(
   // Control
   input  wire logic                        use_mid_i,
   input  wire logic [NUM_CLASSES*MID_W-1:0] mid_match_i,
   // Lookup
   dcs_cls_if.rsp                           lk
);
   always_comb begin
      lk.cls = lk.prio;
      if (use_mid_i) begin
         lk.cls = CLASS_W'(NUM_CLASSES - 1);
         for (int i = NUM_CLASSES - 1; i >= 0; i--) begin
            if (mid_match_i[i*MID_W +: MID_W] == lk.mid) begin
               lk.cls = CLASS_W'(i);
            end
         end
      end
   end
endmodule

//--- design/dcs_cls_if.sv
`timescale 1ns/10ps
// Class lookup request and answer between scheduler and classifier
interface dcs_cls_if;
   import dcs_pkg::*;
   logic [1:0]        prio;
   logic [MID_W-1:0]  mid;
   logic [CLASS_W-1:0] cls;
   modport req (output prio, output mid, input cls);
   modport rsp (input prio, input mid, output cls);
endinterface

//--- design/dcs_pkg.sv
package dcs_pkg;
   // Age limit scaling: field x 16 x 2 DDR3 clock cycles
   localparam int unsigned AGE_SCALE_A      = 16;
   localparam int unsigned AGE_SCALE_B      = 2;
   localparam logic [7:0]  AGE_LIMIT_RESET  = 8'hFF;
   localparam int unsigned AGE_LIMIT_W      = 8;
   localparam int unsigned AGE_CNT_W        = 14;
   localparam int unsigned FIFO_DEPTH       = 8;
   localparam int unsigned NUM_CLASSES      = 4;
   localparam int unsigned CLASS_W          = 2;
   localparam int unsigned LAT_W            = 12;
   localparam int unsigned ADDR_W           = 32;
   localparam int unsigned BANK_W           = 3;
   localparam int unsigned MID_W            = 4;
   localparam logic [11:0] LAT_RESET        = 12'h0FF;
endpackage

//--- design/dcs_scheduler.sv
`timescale 1ns/10ps
// How it works
// - Each queued command is ranked by a service class taken from master priority or master identifier.
// - Every service class has its own programmable latency limit bounding its wait before promotion.
// - A class with a smaller latency limit counts as higher priority than one with a larger limit.
// - An expired read blocks lower-class reads but never any write.
// - An expired write blocks lower-class writes but never any read.
// - Writes to an already open bank win over all but an aged oldest command, even over an expired read.
// - The oldest command is tracked regardless of class and issued once its age limit expires.
// - The age limit in clock cycles is the configured field times 16 times 2.
// - After reset the age limit field holds 0xFF.
module dcs_scheduler
   import dcs_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   // Clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          resetn_i,
   // Configuration
   input  wire logic [AGE_LIMIT_W-1:0]        age_limit_i,
   input  wire logic                          age_limit_load_i,
   input  wire logic [NUM_CLASSES*LAT_W-1:0]  class_lat_i,
   input  wire logic                          use_mid_i,
   input  wire logic [NUM_CLASSES*MID_W-1:0]  mid_match_i,
   // Command in from bus masters
   input  wire logic                          cmd_valid_i,
   output logic                               cmd_ready_o,
   input  wire logic                          cmd_write_i,
   input  wire logic [ADDR_W-1:0]             cmd_addr_i,
   input  wire logic [BANK_W-1:0]             cmd_bank_i,
   input  wire logic [1:0]                    cmd_prio_i,
   input  wire logic [MID_W-1:0]              cmd_mid_i,
   // Memory side
   input  wire logic [(1<<BANK_W)-1:0]        bank_open_i,
   input  wire logic                          mem_ready_i,
   output logic                               mem_valid_o,
   output logic                               mem_write_o,
   output logic [ADDR_W-1:0]                  mem_addr_o,
   output logic [CLASS_W-1:0]                 mem_class_o,
   // Status
   output logic [AGE_LIMIT_W-1:0]             age_limit_o
);
   localparam int IW = $clog2(DEPTH);

   logic rst_s1_q;
   logic rst_n;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   dcs_cls_if lk ();
   assign lk.prio = cmd_prio_i;
   assign lk.mid  = cmd_mid_i;
   dcs_classifier u_cls (
      .use_mid_i   (use_mid_i),
      .mid_match_i (mid_match_i),
      .lk          (lk)
   );

   // Age limit field
   logic [AGE_LIMIT_W-1:0] age_lim_q;
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         age_lim_q <= AGE_LIMIT_RESET;
      end else if (age_limit_load_i) begin
         age_lim_q <= age_limit_i;
      end
   end
   assign age_limit_o = age_lim_q;
   logic [AGE_CNT_W-1:0] age_cycles;
   assign age_cycles = AGE_CNT_W'(age_lim_q) * AGE_CNT_W'(AGE_SCALE_A) * AGE_CNT_W'(AGE_SCALE_B);

   // Command slots
   logic [DEPTH-1:0]  vld_q;
   logic              wr_q   [DEPTH];
   logic [ADDR_W-1:0] addr_q [DEPTH];
   logic [BANK_W-1:0] bank_q [DEPTH];
   logic [CLASS_W-1:0] cls_q [DEPTH];
   logic [LAT_W-1:0]  wait_q [DEPTH];
   logic [AGE_CNT_W-1:0] age_q [DEPTH];
   logic [31:0]       seq_q  [DEPTH];
   logic [31:0]       seq_next_q;

   logic [DEPTH-1:0] expired;
   logic [DEPTH-1:0] aged;
   logic [LAT_W-1:0] lim [DEPTH];

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_slot
         assign lim[g]     = class_lat_i[cls_q[g]*LAT_W +: LAT_W];
         assign expired[g] = vld_q[g] && (wait_q[g] >= lim[g]);
         assign aged[g]    = vld_q[g] && (age_q[g] >= age_cycles);
      end
   endgenerate

   // Free slot search
   logic          free_found;
   logic [IW-1:0] free_idx;
   always_comb begin
      free_found = 1'b0;
      free_idx   = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (!vld_q[i]) begin
            free_found = 1'b1;
            free_idx   = IW'(i);
         end
      end
   end
   assign cmd_ready_o = free_found;

   // Oldest command
   logic [IW-1:0] old_idx;
   always_comb begin
      old_idx = '0;
      for (int i = 0; i < DEPTH; i++) begin
         if (vld_q[i] && (!vld_q[old_idx] || seq_q[i] < seq_q[old_idx])) begin
            old_idx = IW'(i);
         end
      end
   end

   // Per direction: most urgent expired class (smallest limit)
   logic              rd_exp_any, wr_exp_any;
   logic [LAT_W-1:0]  rd_exp_lim, wr_exp_lim;
   always_comb begin
      rd_exp_any = 1'b0;
      wr_exp_any = 1'b0;
      rd_exp_lim = '1;
      wr_exp_lim = '1;
      for (int i = 0; i < DEPTH; i++) begin
         if (expired[i] && !wr_q[i] && lim[i] <= rd_exp_lim) begin
            rd_exp_any = 1'b1;
            rd_exp_lim = lim[i];
         end
         if (expired[i] && wr_q[i] && lim[i] <= wr_exp_lim) begin
            wr_exp_any = 1'b1;
            wr_exp_lim = lim[i];
         end
      end
   end

   // Pick: aged oldest, then open-bank write, then expired, then oldest eligible
   logic          pick_ok;
   logic [IW-1:0] pick_idx;
   logic          elig;
   logic          cand;
   always_comb begin
      pick_ok  = 1'b0;
      pick_idx = '0;
      elig     = 1'b0;
      cand     = 1'b0;
      if (aged[old_idx]) begin
         pick_ok  = 1'b1;
         pick_idx = old_idx;
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            cand = vld_q[i] && wr_q[i] && bank_open_i[bank_q[i]];
            if (!pick_ok && cand) begin
               pick_ok  = 1'b1;
               pick_idx = IW'(i);
            end
         end
         for (int i = 0; i < DEPTH; i++) begin
            cand = expired[i] && (wr_q[i] ? lim[i] == wr_exp_lim : lim[i] == rd_exp_lim);
            if (!pick_ok && cand) begin
               pick_ok  = 1'b1;
               pick_idx = IW'(i);
            end
         end
         for (int i = 0; i < DEPTH; i++) begin
            // Lower classes blocked only within the same direction
            elig = vld_q[i] &&
                   !(!wr_q[i] && rd_exp_any && lim[i] > rd_exp_lim) &&
                   !(wr_q[i] && wr_exp_any && lim[i] > wr_exp_lim);
            if (!pick_ok && elig && (!vld_q[pick_idx] || seq_q[i] < seq_q[pick_idx] || pick_idx == IW'(i))) begin
               pick_idx = IW'(i);
            end
         end
         if (!pick_ok && vld_q[pick_idx]) begin
            pick_ok = !(!wr_q[pick_idx] && rd_exp_any && lim[pick_idx] > rd_exp_lim) &&
                      !(wr_q[pick_idx] && wr_exp_any && lim[pick_idx] > wr_exp_lim);
         end
      end
   end

   logic out_busy_q;
   logic issue;
   assign issue = pick_ok && (!out_busy_q || mem_ready_i);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         seq_next_q <= 32'h0000_0000;
      end else if (cmd_valid_i && free_found) begin
         seq_next_q <= seq_next_q + 32'h0000_0001;
      end
   end

   generate
      for (g = 0; g < DEPTH; g++) begin : g_upd
         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               vld_q[g]  <= 1'b0;
               wr_q[g]   <= 1'b0;
               addr_q[g] <= '0;
               bank_q[g] <= '0;
               cls_q[g]  <= '0;
               wait_q[g] <= '0;
               age_q[g]  <= '0;
               seq_q[g]  <= 32'h0000_0000;
            end else if (cmd_valid_i && free_found && free_idx == IW'(g)) begin
               vld_q[g]  <= 1'b1;
               wr_q[g]   <= cmd_write_i;
               addr_q[g] <= cmd_addr_i;
               bank_q[g] <= cmd_bank_i;
               cls_q[g]  <= lk.cls;
               wait_q[g] <= '0;
               age_q[g]  <= '0;
               seq_q[g]  <= seq_next_q;
            end else if (issue && pick_idx == IW'(g)) begin
               vld_q[g] <= 1'b0;
            end else if (vld_q[g]) begin
               if (wait_q[g] != '1) wait_q[g] <= wait_q[g] + LAT_W'(1);
               if (age_q[g] != '1) age_q[g] <= age_q[g] + AGE_CNT_W'(1);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         out_busy_q  <= 1'b0;
         mem_write_o <= 1'b0;
         mem_addr_o  <= '0;
         mem_class_o <= '0;
      end else if (issue) begin
         out_busy_q  <= 1'b1;
         mem_write_o <= wr_q[pick_idx];
         mem_addr_o  <= addr_q[pick_idx];
         mem_class_o <= cls_q[pick_idx];
      end else if (mem_ready_i) begin
         out_busy_q <= 1'b0;
      end
   end
   assign mem_valid_o = out_busy_q;
endmodule

//--- tb/dcs_master_model.sv
`timescale 1ns/10ps
module dcs_master_model
   import dcs_pkg::*;
(
   // Command bus
   input  wire logic         clk_i,
   input  wire logic         ready_i,
   output logic              valid_o = 0,
   output logic              write_o = 0,
   output logic [ADDR_W-1:0] addr_o  = '0,
   output logic [2:0]        bank_o  = '0,
   output logic [1:0]        prio_o  = '0,
   output logic [3:0]        mid_o   = '0
);
   // Holds a request until taken; idle fields then show the inverse
   task automatic send(input logic w, input logic [ADDR_W-1:0] a, input logic [2:0] b, input logic [1:0] p,
                       input logic [3:0] m);
      @(negedge clk_i);
      {valid_o, write_o, addr_o, bank_o, prio_o, mid_o} = {1'b1, w, a, b, p, m};
      while (ready_i !== 1'b1) @(negedge clk_i);
      @(posedge clk_i);
      @(negedge clk_i);
      {valid_o, write_o, addr_o, bank_o, prio_o, mid_o} = {1'b0, ~w, ~a, ~b, ~p, ~m};
   endtask
endmodule

//--- tb/dcs_scheduler_props.sv
`timescale 1ns/10ps
module dcs_scheduler_props
   import dcs_pkg::*;
(
   // Watched ports
   input wire logic                   clk_i,
   input wire logic                   resetn_i,
   input wire logic [AGE_LIMIT_W-1:0] age_limit_i,
   input wire logic                   age_limit_load_i,
   input wire logic                   use_mid_i,
   input wire logic                   cmd_valid_i,
   input wire logic                   cmd_ready_o,
   input wire logic [ADDR_W-1:0]      cmd_addr_i,
   input wire logic [1:0]             cmd_prio_i,
   input wire logic                   mem_ready_i,
   input wire logic                   mem_valid_o,
   input wire logic                   mem_write_o,
   input wire logic [ADDR_W-1:0]      mem_addr_o,
   input wire logic [CLASS_W-1:0]     mem_class_o,
   input wire logic [AGE_LIMIT_W-1:0] age_limit_o
);
   logic [4:0]        out_q;
   logic              solo_q;
   logic [ADDR_W-1:0] adr_q;
   logic [1:0]        pri_q;
   wire               tk = cmd_valid_i && cmd_ready_o;
   wire               gv = mem_valid_o && mem_ready_i;
   // Commands taken but not yet accepted by memory
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_q  <= '0;
         solo_q <= 1'b0;
      end else begin
         out_q <= out_q + 5'(tk) - 5'(gv);
         // Last take found nothing outstanding, so it is the only one left
         if (tk) begin
            solo_q <= (out_q == '0);
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (tk) begin
         adr_q <= cmd_addr_i;
         pri_q <= cmd_prio_i;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_take; tk && out_q == 0 && !mem_valid_o; endsequence
   sequence s_out; ##[1:3] mem_valid_o; endsequence
   property p_hold; mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_addr_o) && $stable(mem_write_o)
      && $stable(mem_class_o); endproperty
   property p_age_rst; $rose(resetn_i) |-> age_limit_o == AGE_LIMIT_RESET; endproperty
   property p_age_load; age_limit_load_i |=> age_limit_o == $past(age_limit_i); endproperty
   property p_age_keep; !age_limit_load_i |=> $stable(age_limit_o); endproperty
   property p_issue; s_take |-> s_out; endproperty
   property p_phantom; mem_valid_o |-> out_q != 0; endproperty
   property p_solo; mem_valid_o && out_q == 1 && solo_q && !use_mid_i |-> mem_addr_o == adr_q && mem_class_o == pri_q;
   endproperty
   property p_full; !cmd_ready_o |-> out_q >= 8; endproperty
   property p_free; out_q == 0 |-> cmd_ready_o; endproperty
   a_hold:     assert property (p_hold) else $error("memory request changed while waiting");
   a_age_rst:  assert property (p_age_rst) else $error("age field wrong after reset");
   a_age_load: assert property (p_age_load) else $error("age field not loaded");
   a_age_keep: assert property (p_age_keep) else $error("age field changed without load");
   a_issue:    assert property (p_issue) else $error("lone command not issued");
   a_phantom:  assert property (p_phantom) else $error("issue with nothing queued");
   a_solo:     assert property (p_solo) else $error("lone command fields or class wrong");
   a_full:     assert property (p_full) else $error("refused while slots free");
   a_free:     assert property (p_free) else $error("refused while empty");
endmodule
bind dcs_scheduler dcs_scheduler_props chk_u (.clk_i, .resetn_i, .age_limit_i, .age_limit_load_i, .use_mid_i,
   .cmd_valid_i, .cmd_ready_o, .cmd_addr_i, .cmd_prio_i, .mem_ready_i, .mem_valid_o, .mem_write_o, .mem_addr_o,
   .mem_class_o, .age_limit_o);

//--- tb/test_ddr_cmd_service_class_scheduler.sv
`timescale 1ns/10ps
module test_ddr_cmd_service_class_scheduler import dcs_pkg::*;;
   logic                    clk_i = 0, resetn_i = 0, ld = 0, use_mid = 0, mrdy = 0, chk = 1;
   logic                    vld, rdy, wr, mv, mw;
   logic [7:0]              age = 0, bopen = 0, al;
   logic [47:0]             lat = {4{LAT_RESET}};
   logic [ADDR_W-1:0]       ca, ma, a, b, c;
   logic [2:0]              cb;
   logic [1:0]              cp, mc;
   logic [3:0]              cm;
   logic [ADDR_W+CLASS_W:0] q[$];
   int                      bad_count = 0, n_compared = 0, n;
   initial forever #10 clk_i = ~clk_i;
   dcs_master_model mst_u (.clk_i, .ready_i(rdy), .valid_o(vld), .write_o(wr), .addr_o(ca), .bank_o(cb),
      .prio_o(cp), .mid_o(cm));
   dcs_scheduler dut_u (.clk_i, .resetn_i, .age_limit_i(age), .age_limit_load_i(ld), .class_lat_i(lat),
      .use_mid_i(use_mid), .mid_match_i(16'h3210), .cmd_valid_i(vld), .cmd_ready_o(rdy), .cmd_write_i(wr),
      .cmd_addr_i(ca), .cmd_bank_i(cb), .cmd_prio_i(cp), .cmd_mid_i(cm), .bank_open_i(bopen), .mem_ready_i(mrdy),
      .mem_valid_o(mv), .mem_write_o(mw), .mem_addr_o(ma), .mem_class_o(mc), .age_limit_o(al));
   task automatic cmp(input string s, input logic [47:0] e, input logic [47:0] g);
      n_compared++;
      if (e !== g) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic stop_test;
      if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic go(input logic w, input logic [2:0] bk, input logic [1:0] p, input logic [3:0] m,
                     input logic [1:0] cl, input logic psh, output logic [ADDR_W-1:0] ad);
      ad = $urandom;
      if (psh) q.push_back({w, ad, cl});
      mst_u.send(w, ad, bk, p, m);
   endtask
   // Scoreboard: each memory request accepted while chk is set against the oldest note
   always @(posedge clk_i) begin
      if (mv && mrdy && chk) cmp("mem", q.size() ? q.pop_front() : '1, {mw, ma, mc});
   end
   initial begin
      #1ms;
      bad_count++;
      stop_test();
   end
   initial begin
      void'($urandom(47829));
      repeat (8) @(negedge clk_i);
      resetn_i = 1;
      repeat (3) @(negedge clk_i);
      cmp("reset", {1'b1, AGE_LIMIT_RESET}, {rdy, al});
      mrdy = 1;
      for (int i = 0; i < 8; i++) go(i[2], 3'($urandom), i[1:0], 4'($urandom), i[1:0], 1, a);
      use_mid = 1;
      for (int i = 0; i < 5; i++) go(0, 0, 0, i[3:0], i < 4 ? i[1:0] : 2'd3, 1, a);
      repeat (6) @(negedge clk_i);
      use_mid = 0;
      bopen = 8'h04;
      mrdy = 0;
      go(0, 1, 0, 0, 0, 1, a);
      go(0, 1, 0, 0, 0, 0, b);
      go(1, 2, 3, 0, 3, 1, a);
      q.push_back({1'b0, b, 2'd0});
      repeat (4) @(negedge clk_i);
      mrdy = 1;
      repeat (6) @(negedge clk_i);
      lat[11:0] = 12'h0_002;
      for (int w = 0; w < 2; w++) begin
         mrdy = 0;
         go(w[0], 0, 0, 0, 0, 1, a);
         go(w[0], 0, 3, 0, 3, 0, a);
         go(w[0], 0, 0, 0, 0, 1, b);
         q.push_back({w[0], a, 2'd3});
         repeat (8) @(negedge clk_i);
         mrdy = 1;
         repeat (8) @(negedge clk_i);
      end
      age = 8'h21;
      ld = 1;
      @(negedge clk_i);
      ld = 0;
      cmp("age", 8'h21, al);
      bopen = 8'hFE;
      chk = 0;
      mrdy = 0;
      go(1, 1, 0, 0, 0, 0, a);
      go(0, 0, 0, 0, 0, 0, b);
      fork
         repeat (600) go(1, 1, 0, 0, 0, 0, c);
      join_none
      n = 0;
      // Memory takes one request in four so open-bank writes always queue ahead of the read
      while (n < 1300 && !(mv && mrdy && ma === b)) begin
         @(negedge clk_i);
         mrdy = (n % 4 == 3);
         n++;
      end
      cmp("aged", 1, n >= 33 * 16 * 2 && n <= 33 * 16 * 2 + 40);
      mrdy = 1;
      wait fork;
      repeat (20) @(negedge clk_i);
      chk = 1;
      repeat (4) @(negedge clk_i);
      cmp("left", 0, q.size());
      stop_test();
   end
endmodule
